// >>> rtl/vps_cfg.svh
`ifndef VPS_CFG_SVH
`define VPS_CFG_SVH

`define VPS_CORE_HZ           200000000
`define VPS_BCLK_SLOW_HZ      128000
`define VPS_BCLK_MID_HZ       256000
`define VPS_BCLK_FAST_HZ      512000
`define VPS_SLAVE_BCLK_MAX_HZ 2048000
`define VPS_FRAME_HZ          8000
`define VPS_LONG_SYNC_CYC     8
`define VPS_MAX_LINKS         3
`define VPS_FIFO_DEPTH        8

`define VPS_OFS_CTRL          8'h00
`define VPS_OFS_SLOTS         8'h04
`define VPS_OFS_STATUS        8'h08
`define VPS_OFS_RXDATA        8'h0C
`define VPS_OFS_TX0           8'h10

`define VPS_CTRL_W            18
`define VPS_CTRL_RST          18'h00000
`define VPS_SLOTS_RST         4'h0
`define VPS_STAT_OVR_BIT      0

`endif

// >>> rtl/vps_pkg.sv
`default_nettype none
package vps_pkg;

  typedef enum logic [1:0] {VPS_FMT_LONG, VPS_FMT_SHORT, VPS_FMT_GCI} vps_fmt_t;
  typedef enum logic [1:0] {VPS_LIN13, VPS_LIN16, VPS_ULAW, VPS_ALAW} vps_sample_t;
  typedef enum logic [1:0] {VPS_FILL_SIGN, VPS_FILL_ZERO, VPS_FILL_ATTEN} vps_fill_t;
  typedef enum logic [1:0] {VPS_BCLK_SLOW, VPS_BCLK_MID, VPS_BCLK_FAST} vps_rate_t;
  typedef enum logic [1:0] {VPS_IDLE, VPS_ARMED, VPS_ACTIVE} vps_state_t;

  typedef struct packed {
    logic [2:0]  atten;
    vps_rate_t   rate;
    logic        sync_mute;
    logic        mute;
    logic        late_release;
    logic        lsb_first;
    vps_fill_t   fill;
    logic        slot16;
    vps_sample_t sample;
    vps_fmt_t    fmt;
    logic        master;
    logic        enable;
  } vps_ctrl_t;

  typedef struct packed {
    logic       in_frame;
    logic       cap;
    logic       last;
    logic [1:0] slot;
    logic [3:0] k;
  } vps_bit_t;

  typedef struct packed {
    logic [1:0]  slot;
    logic [15:0] word;
  } vps_rx_t;

endpackage
`default_nettype wire

// >>> rtl/vps_fifo.sv
`default_nettype none
module vps_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk_in,
  input  wire logic                       rst_b_in,
  input  wire logic                       ce_in,
  input  wire logic                       wr_valid_in,
  output logic                            wr_ready_out,
  input  wire logic [WIDTH-1:0]           wr_data_in,
  output logic                            rd_valid_out,
  input  wire logic                       rd_ready_in,
  output logic [WIDTH-1:0]                rd_data_out,
  output logic [$clog2(DEPTH+1)-1:0]      level_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [LW-1:0]    count;
  logic             push;
  logic             pop;

  assign wr_ready_out = (count != LW'(DEPTH));
  assign rd_valid_out = (count != '0);
  assign rd_data_out  = mem[rd_ptr];
  assign level_out    = count;
  assign push         = wr_valid_in & wr_ready_out;
  assign pop          = rd_ready_in & rd_valid_out;

  always_ff @(posedge clk_in) begin
    if (ce_in && push) begin
      mem[wr_ptr] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (ce_in) begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        count <= LW'(count + 1'b1);
      end else if (pop && !push) begin
        count <= LW'(count - 1'b1);
      end
    end
  end
endmodule // vps_fifo
`default_nettype wire

// >>> rtl/vps_port.sv
`include "vps_cfg.svh"
`default_nettype none
module vps_port #(
  parameter int FIFO_DEPTH = `VPS_FIFO_DEPTH
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        ce_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic [1:0]       s_axi_bresp_out,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [7:0]  s_axi_araddr_in,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  input  wire logic        bclk_in,
  output logic             bclk_out,
  output logic             bclk_oe_out,
  input  wire logic        fsync_in,
  output logic             fsync_out,
  output logic             fsync_oe_out,
  input  wire logic        sdin_in,
  output logic             sdout_out,
  output logic             sdout_oe_out
);
  localparam int LW = $clog2(FIFO_DEPTH + 1);
  localparam int HALF_SLOW = `VPS_CORE_HZ / (2 * `VPS_BCLK_SLOW_HZ);
  localparam int HALF_MID  = `VPS_CORE_HZ / (2 * `VPS_BCLK_MID_HZ);
  localparam int HALF_FAST = `VPS_CORE_HZ / (2 * `VPS_BCLK_FAST_HZ);
  localparam int FC_SLOW   = `VPS_BCLK_SLOW_HZ / `VPS_FRAME_HZ;
  localparam int FC_MID    = `VPS_BCLK_MID_HZ / `VPS_FRAME_HZ;
  localparam int FC_FAST   = `VPS_BCLK_FAST_HZ / `VPS_FRAME_HZ;

  vps_pkg::vps_ctrl_t  ctrl;
  vps_pkg::vps_state_t state;
  vps_pkg::vps_bit_t   lb;
  vps_pkg::vps_bit_t   cb;
  vps_pkg::vps_rx_t    rx_entry;
  vps_pkg::vps_rx_t    rx_head;
  logic [3:0]  slot_en;
  logic [3:0]  slot_eff;
  logic [15:0] tx_slot [4];
  logic [15:0] tx_shadow [4];
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        ar_hs;
  logic        next_aw_held;
  logic        next_w_held;
  logic        next_bvalid;
  logic        next_rvalid;
  logic [32:0] rd_word;
  logic [31:0] wr_merged;
  logic        overrun;
  logic        push;
  logic        fifo_ready;
  logic        fifo_valid;
  logic        pop;
  logic [LW-1:0] fifo_level;
  logic [2:0]  clk_s;
  logic [2:0]  sync_s;
  logic [1:0]  sdin_s;
  logic [9:0]  div_cnt;
  logic [9:0]  half_m1;
  logic [6:0]  mcyc;
  logic [6:0]  fc_m1;
  logic [6:0]  next_mcyc;
  logic        lclk;
  logic        lclk_d;
  logic        lsync;
  logic        lsync_d;
  logic        rise_ev;
  logic        fall_ev;
  logic        go_long;
  logic        go_short;
  logic        launch_ev;
  logic        cap_ev;
  logic [6:0]  pos;
  logic [6:0]  launch_pos;
  logic [15:0] rx_sh;
  logic [15:0] rx_next;

  // Master timing; the divider rounds each half period down to whole core cycles.
  always_comb begin
    case (ctrl.rate)
      vps_pkg::VPS_BCLK_MID: begin
        half_m1 = 10'(HALF_MID - 1);
        fc_m1   = 7'(FC_MID - 1);
      end
      vps_pkg::VPS_BCLK_FAST: begin
        half_m1 = 10'(HALF_FAST - 1);
        fc_m1   = 7'(FC_FAST - 1);
      end
      default: begin
        half_m1 = 10'(HALF_SLOW - 1);
        fc_m1   = 7'(FC_SLOW - 1);
      end
    endcase
  end

  assign next_mcyc = (mcyc == fc_m1) ? 7'h00 : 7'(mcyc + 7'h01);

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_cnt   <= 10'h000;
      bclk_out  <= 1'b0;
      fsync_out <= 1'b0;
      mcyc      <= 7'h00;
    end else if (ce_in) begin
      if (!(ctrl.enable && ctrl.master)) begin
        div_cnt   <= 10'h000;
        bclk_out  <= 1'b0;
        fsync_out <= 1'b0;
        mcyc      <= fc_m1;
      end else if (div_cnt == half_m1) begin
        div_cnt  <= 10'h000;
        bclk_out <= ~bclk_out;
        if (!bclk_out) begin
          mcyc <= next_mcyc;
          if (ctrl.sync_mute) begin
            fsync_out <= 1'b0;
          end else begin
            case (ctrl.fmt)
              vps_pkg::VPS_FMT_SHORT: fsync_out <= (next_mcyc == fc_m1);
              vps_pkg::VPS_FMT_GCI:   fsync_out <= (next_mcyc == 7'h00);
              default: fsync_out <= (next_mcyc < 7'(`VPS_LONG_SYNC_CYC));
            endcase
          end
        end
      end else begin
        div_cnt <= 10'(div_cnt + 10'h001);
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bclk_oe_out  <= 1'b0;
      fsync_oe_out <= 1'b0;
    end else if (ce_in) begin
      bclk_oe_out  <= ctrl.enable & ctrl.master;
      fsync_oe_out <= ctrl.enable & ctrl.master;
    end
  end

  // Pins are synchronised; the 48.8 core cycles of a 2048 kHz half period leave ample margin.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clk_s  <= 3'h0;
      sync_s <= 3'h0;
      sdin_s <= 2'h0;
    end else if (ce_in) begin
      clk_s  <= {clk_s[1:0], bclk_in};
      sync_s <= {sync_s[1:0], fsync_in};
      sdin_s <= {sdin_s[0], sdin_in};
    end
  end

  assign lclk    = ctrl.master ? bclk_out : clk_s[2];
  assign lsync   = ctrl.master ? fsync_out : sync_s[2];
  assign rise_ev = lclk & ~lclk_d;
  assign fall_ev = ~lclk & lclk_d;

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lclk_d  <= 1'b0;
      lsync_d <= 1'b0;
    end else if (ce_in) begin
      lclk_d  <= lclk;
      lsync_d <= lsync;
    end
  end

  function automatic vps_pkg::vps_bit_t bit_info(input logic [6:0] p);
    vps_pkg::vps_bit_t r;
    logic [6:0] b;
    b = (ctrl.fmt == vps_pkg::VPS_FMT_GCI) ? {1'b0, p[6:1]} : p;
    r.cap = (ctrl.fmt != vps_pkg::VPS_FMT_GCI) | p[0];
    if (ctrl.slot16 && ctrl.fmt != vps_pkg::VPS_FMT_GCI) begin
      r.in_frame = ~b[6];
      r.slot     = b[5:4];
      r.k        = b[3:0];
      r.last     = (b[3:0] == 4'hF);
    end else begin
      r.in_frame = (b[6:5] == 2'h0);
      r.slot     = b[4:3];
      r.k        = {1'b0, b[2:0]};
      r.last     = (b[2:0] == 3'h7);
    end
    return r;
  endfunction

  function automatic logic [3:0] bit_index(input logic [3:0] k, input logic wide);
    if (ctrl.lsb_first) begin
      return k;
    end
    return wide ? 4'(4'hF - k) : 4'(4'h7 - k);
  endfunction

  function automatic logic [15:0] fill_word(input logic [15:0] s);
    logic        lin13;
    logic [15:0] w;
    lin13 = (ctrl.sample == vps_pkg::VPS_LIN13);
    case (ctrl.sample)
      vps_pkg::VPS_LIN16: w = s;
      vps_pkg::VPS_LIN13: w = {s[12:0], 3'h0};
      default: w = {s[7:0], 8'h00};
    endcase
    case (ctrl.fill)
      vps_pkg::VPS_FILL_SIGN: w = lin13 ? {{3{s[12]}}, s[12:0]} : {{8{s[7]}}, s[7:0]};
      vps_pkg::VPS_FILL_ATTEN: w = {w[15:3], ctrl.atten};
      default: w = w;
    endcase
    if (ctrl.sample == vps_pkg::VPS_LIN16) begin
      w = s;
    end
    return w;
  endfunction

  // A fourth enabled slot is ignored so that at most three links run at once.
  assign slot_eff = (slot_en == 4'hF) ? 4'h7 : slot_en;

  assign go_long    = (ctrl.fmt != vps_pkg::VPS_FMT_SHORT) & lsync & ~lsync_d;
  assign go_short   = (state == vps_pkg::VPS_ARMED) & rise_ev;
  assign launch_ev  = go_long | go_short | ((state == vps_pkg::VPS_ACTIVE) & rise_ev);
  assign launch_pos = (go_long | go_short) ? 7'h00 : 7'(pos + 7'h01);
  assign cap_ev     = (state == vps_pkg::VPS_ACTIVE) & fall_ev & ~go_long;
  assign lb         = bit_info(launch_pos);
  assign cb         = bit_info(pos);

  // A new long sync restarts the frame, which relies on a steady partner clock.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= vps_pkg::VPS_IDLE;
      pos   <= 7'h00;
    end else if (ce_in) begin
      if (!ctrl.enable) begin
        state <= vps_pkg::VPS_IDLE;
      end else if (go_long || go_short) begin
        state <= vps_pkg::VPS_ACTIVE;
        pos   <= 7'h00;
      end else if (ctrl.fmt == vps_pkg::VPS_FMT_SHORT && fall_ev && lsync) begin
        state <= vps_pkg::VPS_ARMED;
      end else if (state == vps_pkg::VPS_ACTIVE && rise_ev) begin
        pos <= launch_pos;
        if (!lb.in_frame) begin
          state <= vps_pkg::VPS_IDLE;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sdout_out    <= 1'b0;
      sdout_oe_out <= 1'b0;
    end else if (ce_in) begin
      if (!ctrl.enable) begin
        sdout_oe_out <= 1'b0;
        sdout_out    <= 1'b0;
      end else if (launch_ev) begin
        sdout_oe_out <= lb.in_frame & slot_eff[lb.slot];
        sdout_out    <= lb.in_frame & ~ctrl.mute & tx_bit(lb);
      end else if (cap_ev && cb.last && cb.cap && !ctrl.late_release) begin
        sdout_oe_out <= 1'b0;
      end
    end
  end

  function automatic logic tx_bit(input vps_pkg::vps_bit_t b);
    logic        wide;
    logic [15:0] w;
    wide = ctrl.slot16 & (ctrl.fmt != vps_pkg::VPS_FMT_GCI);
    w    = wide ? fill_word(tx_shadow[b.slot]) : {8'h00, tx_shadow[b.slot][7:0]};
    return w[bit_index(b.k, wide)];
  endfunction

  always_comb begin
    rx_next = rx_sh;
    rx_next[bit_index(cb.k, ctrl.slot16 & (ctrl.fmt != vps_pkg::VPS_FMT_GCI))] = sdin_s[1];
  end

  assign push     = cap_ev & cb.cap & cb.last & cb.in_frame & slot_eff[cb.slot];
  assign rx_entry = '{slot: cb.slot, word: rx_next};

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_sh <= 16'h0000;
    end else if (ce_in) begin
      if (launch_ev && launch_pos == 7'h00) begin
        rx_sh <= 16'h0000;
      end else if (cap_ev && cb.cap) begin
        rx_sh <= (cb.last) ? 16'h0000 : rx_next;
      end
    end
  end

  vps_fifo #(
    .WIDTH ($bits(vps_pkg::vps_rx_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_in       (core_clk_in),
    .rst_b_in     (rst_b_in),
    .ce_in        (ce_in),
    .wr_valid_in  (push),
    .wr_ready_out (fifo_ready),
    .wr_data_in   (rx_entry),
    .rd_valid_out (fifo_valid),
    .rd_ready_in  (pop),
    .rd_data_out  (rx_head),
    .level_out    (fifo_level)
  );

  // Audio cannot wait, so a full buffer drops the word and records the loss.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      overrun <= 1'b0;
    end else if (ce_in) begin
      if (push && !fifo_ready) begin
        overrun <= 1'b1;
      end else if (do_write && aw_addr == `VPS_OFS_STATUS
                   && w_strb[0] && w_data[`VPS_STAT_OVR_BIT]) begin
        overrun <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (w_strb[i]) begin
        r[8*i +: 8] = w_data[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign do_write     = aw_held & w_held & ~s_axi_bvalid_out;
  assign ar_hs        = s_axi_arvalid_in & s_axi_arready_out;
  assign next_aw_held = (aw_held | (s_axi_awvalid_in & s_axi_awready_out)) & ~do_write;
  assign next_w_held  = (w_held | (s_axi_wvalid_in & s_axi_wready_out)) & ~do_write;
  assign next_bvalid  = do_write | (s_axi_bvalid_out & ~s_axi_bready_in);
  assign next_rvalid  = ar_hs | (s_axi_rvalid_out & ~s_axi_rready_in);
  assign pop          = ar_hs & (s_axi_araddr_in == `VPS_OFS_RXDATA) & fifo_valid;
  assign wr_merged    = merge(32'(ctrl));

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      aw_addr           <= 8'h00;
      w_data            <= 32'h00000000;
      w_strb            <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= 2'h0;
    end else if (ce_in) begin
      aw_held           <= next_aw_held;
      w_held            <= next_w_held;
      s_axi_awready_out <= ~next_aw_held & ~next_bvalid;
      s_axi_wready_out  <= ~next_w_held & ~next_bvalid;
      s_axi_bvalid_out  <= next_bvalid;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (do_write) begin
        s_axi_bresp_out <= (aw_addr <= 8'h1C && aw_addr[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl    <= `VPS_CTRL_RST;
      slot_en <= `VPS_SLOTS_RST;
    end else if (ce_in && do_write) begin
      if (aw_addr == `VPS_OFS_CTRL) begin
        ctrl <= vps_pkg::vps_ctrl_t'(wr_merged[`VPS_CTRL_W-1:0]);
      end
      if (aw_addr == `VPS_OFS_SLOTS && w_strb[0]) begin
        slot_en <= w_data[3:0];
      end
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_tx
    logic [31:0] tx_merged;
    assign tx_merged = merge({16'h0000, tx_slot[i]});
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        tx_slot[i]   <= 16'h0000;
        tx_shadow[i] <= 16'h0000;
      end else if (ce_in) begin
        if (do_write && aw_addr == 8'(`VPS_OFS_TX0 + 4 * i)) begin
          tx_slot[i] <= tx_merged[15:0];
        end
        if (go_long || go_short) begin
          tx_shadow[i] <= tx_slot[i];
        end
      end
    end
  end

  always_comb begin
    case (s_axi_araddr_in)
      `VPS_OFS_CTRL:   rd_word = {1'b0, 32'(ctrl)};
      `VPS_OFS_SLOTS:  rd_word = {1'b0, 28'h0000000, slot_en};
      `VPS_OFS_STATUS: rd_word = {1'b0, 16'(fifo_level), 12'h000, 2'(state),
                                  fifo_valid, overrun};
      `VPS_OFS_RXDATA: rd_word = {1'b0, 13'h0000, fifo_valid, rx_head};
      8'h10:           rd_word = {1'b0, 16'h0000, tx_slot[0]};
      8'h14:           rd_word = {1'b0, 16'h0000, tx_slot[1]};
      8'h18:           rd_word = {1'b0, 16'h0000, tx_slot[2]};
      8'h1C:           rd_word = {1'b0, 16'h0000, tx_slot[3]};
      default:         rd_word = {1'b1, 32'h00000000};
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= 2'h0;
    end else if (ce_in) begin
      s_axi_arready_out <= ~next_rvalid;
      s_axi_rvalid_out  <= next_rvalid;
      if (ar_hs) begin
        s_axi_rdata_out <= rd_word[31:0];
        s_axi_rresp_out <= rd_word[32] ? 2'h2 : 2'h0;
      end
    end
  end
endmodule // vps_port
`default_nettype wire

// >>> verif/vps_port_checker.sv
`default_nettype none
module vps_port_checker (
  input wire logic        core_clk_in,
  input wire logic        rst_b_in,
  input wire logic        ce_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        bclk_in,
  input wire logic        bclk_out,
  input wire logic        bclk_oe_out,
  input wire logic        fsync_out,
  input wire logic        fsync_oe_out,
  input wire logic        sdout_out,
  input wire logic        sdout_oe_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [9:0] half_cnt;
  logic       half_seen;
  // The first half period after enable is skipped, since its start is not aligned.
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      half_cnt  <= 10'h000;
      half_seen <= 1'b0;
    end else if (ce_in) begin
      half_cnt  <= $changed(bclk_out) ? 10'h000 : half_cnt + 10'h001;
      half_seen <= bclk_oe_out && (half_seen || $changed(bclk_out));
    end
  end
  AST_OE_PAIR: assert property (bclk_oe_out == fsync_oe_out)
    else $error("clock and sync enables differ");
  AST_SYNC_ON_RISE: assert property ($rose(fsync_out) && fsync_oe_out |-> bclk_out)
    else $error("sync rose outside a high bit clock");
  AST_SD_ON_RISE: assert property (
    sdout_oe_out && $past(sdout_oe_out) && $changed(sdout_out)
    |-> (bclk_oe_out ? bclk_out : bclk_in)) else $error("data changed in clock low phase");
  AST_HALF: assert property (
    $changed(bclk_out) && half_seen && bclk_oe_out |-> half_cnt inside {10'h0C2, 10'h185, 10'h30C})
    else $error("bit clock half period wrong");
  AST_BHOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write response dropped");
  AST_RHOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  AST_BTIME: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("write response late");
  AST_RTIME: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read response late");
endmodule // vps_port_checker
bind vps_port vps_port_checker chk_u (.*);
`default_nettype wire

// >>> verif/vps_codec_model.sv
`default_nettype none
module vps_codec_model #(
  parameter int FRAME_BITS = 32
) (
  input  wire logic [7:0] word_in,
  input  wire logic       long_in,
  output logic            bclk_out,
  output logic            fsync_out,
  output logic            sdin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  int bit_idx;
  initial begin
    {bclk_out, fsync_out, sdin_out} = 3'h0;
    bit_idx = 0;
    #3;
    forever begin
      #80 bclk_out = 1'b1;
      // Long sync spans eight falling edges, far below the half frame limit.
      fsync_out = long_in ? (bit_idx < 8) : (bit_idx == FRAME_BITS - 1);
      // Idle bits toggle so a stale level can never pass for data.
      sdin_out = (bit_idx < 8) ? word_in[7 - bit_idx] : ~sdin_out;
      bit_idx = (bit_idx + 1) % FRAME_BITS;
      #80 bclk_out = 1'b0;
    end
  end
endmodule // vps_codec_model
`default_nettype wire

// >>> verif/vps_port_tb_top.sv
`default_nettype none
module vps_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_b, awv, wv, br, arv, rr, mst, lg;
  logic        awr, wr, bv, arr, rv, bc, bco, fs, so, soe, sv, mbc, mfs, msd;
  logic [1:0]  bresp, rresp;
  logic [7:0]  aa, ra, mw, q;
  logic [31:0] wd, got, rdata, lfsr;
  int          error_cnt, compares, c;
  vps_port dut_u (
    .core_clk_in(clk), .rst_b_in(rst_b), .ce_in(1'b1), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_awaddr_in(aa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
    .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ra), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .bclk_in(mbc), .bclk_out(bc), .bclk_oe_out(bco), .fsync_in(mfs),
    .fsync_out(fs), .fsync_oe_out(), .sdin_in(mst ? (soe ? so : ~so) : msd), .sdout_out(so),
    .sdout_oe_out(soe));
  vps_codec_model codec_u (.word_in(mw), .long_in(lg), .bclk_out(mbc), .fsync_out(mfs),
    .sdin_out(msd));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    {awv, wv, br} <= 3'h7;
    aa <= a;
    wd <= d;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axr(input logic [7:0] a, input logic [1:0] er);
    @(posedge clk);
    {arv, rr} <= 2'h3;
    ra <= a;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
    got = rdata;
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // Waits for the bit clock (s=0) or sync (s=1) to reach v; sv keeps the last data bit.
  task automatic wt(input bit s, input logic v);
    while ((s ? fs : bc) !== v) begin
      sv = so;
      @(posedge clk);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #200us;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {rst_b, awv, wv, br, arv, rr, aa, ra, wd, mw, lg} = '0;
    {mst, lfsr, error_cnt, compares} = {1'b1, 32'h0000DFD1, 64'h0};
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    axr(8'h00, 2'h0);
    chk(got, 32'h0);
    axr(8'h40, 2'h2);
    axw(8'h44, 32'h1, 2'h2);
    lfsr = nxt(nxt(lfsr));
    axw(8'h10, {24'h0, lfsr[7:0]}, 2'h0);
    axw(8'h04, 32'h1, 2'h0);
    axw(8'h00, 32'h4023, 2'h0);
    axr(8'h00, 2'h0);
    chk({got[31:1], bco}, 32'h4023);
    wt(1, 0);
    wt(1, 1);
    {c, q} = {32'h1, 8'h0};
    repeat (8) begin
      wt(0, 0);
      q = {q[6:0], sv};
      wt(0, 1);
      c += fs;
    end
    chk(c, 8);
    chk({24'h0, q}, {24'h0, lfsr[7:0]});
    do begin axr(8'h0C, 2'h0); end while (got[18] !== 1'b1);
    chk(got, {13'h0, 1'b1, 10'h0, lfsr[7:0]});
    axw(8'h00, 32'h0, 2'h0);
    repeat (9) axr(8'h0C, 2'h0);
    mst <= 1'b0;
    mw <= lfsr[15:8];
    axw(8'h00, 32'h35, 2'h0);
    do begin axr(8'h08, 2'h0); end while (got[0] !== 1'b1);
    chk({27'h0, got[19:16], got[0]}, 32'h11);
    axr(8'h0C, 2'h0);
    chk(got, {13'h0, 1'b1, 10'h0, lfsr[15:8]});
    axw(8'h08, 32'h1, 2'h0);
    axr(8'h08, 2'h0);
    chk({31'h0, got[0]}, 32'h0);
    axw(8'h00, 32'h0, 2'h0);
    lg <= 1'b1;
    mw <= lfsr[23:16];
    repeat (9) axr(8'h0C, 2'h0);
    // The model reshapes its sync only at its next bit clock rise, so the port stays off for over a bit time.
    repeat (40) @(posedge clk);
    axw(8'h00, 32'h31, 2'h0);
    do begin axr(8'h0C, 2'h0); end while (got[18] !== 1'b1);
    chk(got, {13'h0, 1'b1, 10'h0, lfsr[23:16]});
    report_and_stop();
  end
endmodule // vps_port_tb_top
`default_nettype wire
